/* verilog/brk_cpu_end.sv */
// processor-side sequencer for the breakpoint unit, driven by software over wishbone
// assumes a classic wishbone master on sys_clk and the unit on the link
`timescale 1ns/1ps
`default_nettype none
module brk_cpu_end
    import brk_pkg::*;
(
    input  wire logic        sys_clk,  // bus clock
    input  wire logic        rst,      // synchronous reset, high
    input  wire logic        ce,       // clock enable, freezes all state
    brk_link_if.cpu          lnk,      // link to the unit
    input  wire logic        wb_cyc_i, // wishbone cycle
    input  wire logic        wb_stb_i, // wishbone strobe
    input  wire logic        wb_we_i,  // wishbone write
    input  wire logic [7:0]  wb_adr_i, // byte address
    input  wire logic [3:0]  wb_sel_i, // byte selects
    input  wire logic [31:0] wb_dat_i, // write data
    output logic [31:0]      wb_dat_o, // read data
    output logic             wb_ack_o, // acknowledge
    output logic             irq       // level interrupt
);
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_BREAK = 2'b10
    } seq_type;

    seq_type             state_ff;
    logic [31:0]         wb_dat_ff;
    logic                wb_ack_ff;
    logic                irq_ff;
    logic [15:0]         pc_addr_ff;
    logic                pc_valid_ff;
    logic                instr_last_ff;
    logic                last_seen_ff;
    logic [2:0]          reg_sel_ff;
    logic                reg_wr_ff;
    logic                reg_rd_ff;
    logic [7:0]          reg_wdata_ff;
    logic                rd_pend_ff;
    logic [7:0]          rd_data_ff;
    logic                break_start_ff;
    logic                rti_ff;
    logic                wait_ff;
    logic                stop_ff;
    logic                monitor_ff;
    logic [7:0]          ir_ff;
    logic [15:0]         vector_ff;
    logic [IRQ_W-1:0]    irq_stat_ff;
    logic [IRQ_W-1:0]    irq_mask_ff;
    logic                wb_req;
    logic                take_break;
    logic [IRQ_W-1:0]    irq_evt;

    function automatic logic wb_wr(input logic [7:0] off);
        wb_wr = wb_req && wb_we_i && (wb_adr_i == off) && wb_sel_i[0];
    endfunction : wb_wr

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
    // boundary: last address cycle of an instruction, or an instruction-done order
    // a last-cycle match raises its request one cycle later, so that cycle is remembered
    assign take_break = (state_ff == ST_RUN) && lnk.break_req && !break_start_ff
                        && (instr_last_ff || last_seen_ff
                            || (wb_wr(WB_MODE) && wb_dat_i[4]));
    assign irq_evt = {reg_rd_ff, break_start_ff};

    // wishbone answer: ack one cycle after the request, unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_ff <= wb_req;
            unique case (wb_adr_i)
                WB_STATUS:   wb_dat_ff <= {vector_ff, 4'h0, wait_ff, stop_ff,
                                           state_ff == ST_BREAK, lnk.break_req, rd_data_ff};
                WB_IRQ_STAT: wb_dat_ff <= {30'h0000_0000, irq_stat_ff};
                WB_IRQ_MASK: wb_dat_ff <= {30'h0000_0000, irq_mask_ff};
                WB_MODE:     wb_dat_ff <= {24'h00_0000, ir_ff};
                default:     wb_dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    // one-cycle link strobes from software orders
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_wr_ff     <= 1'b0;
            reg_rd_ff     <= 1'b0;
            reg_sel_ff    <= 3'h0;
            reg_wdata_ff  <= 8'h00;
            pc_valid_ff   <= 1'b0;
            instr_last_ff <= 1'b0;
            last_seen_ff  <= 1'b0;
            pc_addr_ff    <= 16'h0000;
        end else if (ce) begin
            reg_wr_ff     <= wb_wr(WB_CMD) && wb_dat_i[3];
            reg_rd_ff     <= wb_wr(WB_CMD) && wb_dat_i[4];
            pc_valid_ff   <= wb_wr(WB_ADDR);
            instr_last_ff <= wb_wr(WB_ADDR) && wb_dat_i[16];
            last_seen_ff  <= instr_last_ff;
            if (wb_wr(WB_CMD)) begin
                reg_sel_ff   <= wb_dat_i[2:0];
                reg_wdata_ff <= wb_dat_i[15:8];
            end
            if (wb_wr(WB_ADDR)) begin
                pc_addr_ff <= wb_dat_i[15:0];
            end
        end
    end

    // read data from the unit arrives one cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_pend_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end else if (ce) begin
            rd_pend_ff <= reg_rd_ff;
            if (rd_pend_ff) begin
                rd_data_ff <= lnk.reg_rdata;
            end
        end
    end

    // break sequence: load opcode and vector, leave standby, end on return
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff       <= ST_RUN;
            break_start_ff <= 1'b0;
            rti_ff         <= 1'b0;
            ir_ff          <= 8'h00;
            vector_ff      <= 16'h0000;
            wait_ff        <= 1'b0;
            stop_ff        <= 1'b0;
            monitor_ff     <= 1'b0;
        end else if (ce) begin
            break_start_ff <= take_break;
            rti_ff         <= 1'b0;
            if (wb_wr(WB_MODE)) begin
                monitor_ff <= wb_dat_i[3];
            end
            unique case (state_ff)
                ST_RUN: begin
                    if (wb_wr(WB_MODE)) begin
                        wait_ff <= wb_dat_i[0];
                        stop_ff <= wb_dat_i[1];
                    end
                    if (break_start_ff) begin
                        state_ff  <= ST_BREAK;
                        ir_ff     <= SWI_OPCODE;
                        vector_ff <= monitor_ff ? VEC_MONITOR : VEC_NORMAL;
                        wait_ff   <= 1'b0;
                        stop_ff   <= 1'b0;
                    end
                end
                ST_BREAK: begin
                    if (wb_wr(WB_MODE) && wb_dat_i[5]) begin
                        rti_ff   <= 1'b1;
                        state_ff <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff      <= 1'b0;
        end else if (ce) begin
            irq_stat_ff <= irq_evt
                         | (irq_stat_ff & ~(wb_wr(WB_IRQ_STAT) ? wb_dat_i[IRQ_W-1:0] : '0));
            if (wb_wr(WB_IRQ_MASK)) begin
                irq_mask_ff <= wb_dat_i[IRQ_W-1:0];
            end
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign lnk.pc_addr     = pc_addr_ff;
    assign lnk.pc_valid    = pc_valid_ff;
    assign lnk.instr_last  = instr_last_ff;
    assign lnk.reg_sel     = reg_sel_ff;
    assign lnk.reg_wr      = reg_wr_ff;
    assign lnk.reg_rd      = reg_rd_ff;
    assign lnk.reg_wdata   = reg_wdata_ff;
    assign lnk.break_start = break_start_ff;
    assign lnk.rti_done    = rti_ff;
    // wait/stop shown to the unit only while running, as the flags are cleared at break start
    assign lnk.in_wait     = wait_ff;
    assign lnk.in_stop     = stop_ff;
    assign wb_dat_o        = wb_dat_ff;
    assign wb_ack_o        = wb_ack_ff;
    assign irq             = irq_ff;
endmodule : brk_cpu_end
`default_nettype wire

/* verilog/brk_pkg.sv */
// constants shared by the breakpoint unit, its processor-side end and the link
// assumes a single 100 MHz sys_clk domain for both ends
package brk_pkg;
    // device register indices on the link
    localparam logic [2:0]  IDX_CTRL_STATUS = 3'h0;
    localparam logic [2:0]  IDX_ADDR_HIGH   = 3'h1;
    localparam logic [2:0]  IDX_ADDR_LOW    = 3'h2;
    localparam logic [2:0]  IDX_STANDBY     = 3'h3;
    localparam logic [2:0]  IDX_FLAG_CLEAR  = 3'h4;
    // field positions
    localparam int          BIT_MATCH_EN    = 7;
    localparam int          BIT_ACTIVE      = 6;
    localparam int          BIT_WAIT_EXIT   = 1;
    localparam int          BIT_STBY_EXIT   = 0;
    localparam int          BIT_CLR_EN      = 7;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    // break vectors
    localparam logic [15:0] VEC_NORMAL      = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR     = 16'hFEFC;
    // opcode loaded at break start; value arbitrary
    localparam logic [7:0]  SWI_OPCODE      = 8'h00;
    // host wishbone byte offsets
    localparam logic [7:0]  WB_CMD          = 8'h00;
    localparam logic [7:0]  WB_ADDR         = 8'h04;
    localparam logic [7:0]  WB_MODE         = 8'h08;
    localparam logic [7:0]  WB_STATUS       = 8'h0C;
    localparam logic [7:0]  WB_IRQ_STAT     = 8'h10;
    localparam logic [7:0]  WB_IRQ_MASK     = 8'h14;
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_BRK         = 0;
    localparam int          IRQ_RD          = 1;
endpackage : brk_pkg

/* verilog/brk_link_if.sv */
// link between the breakpoint unit and the processor-side sequencer
// assumes both ends run on the same sys_clk
`timescale 1ns/1ps
`default_nettype none
interface brk_link_if;
    logic [15:0] pc_addr;     // processor-generated address
    logic        pc_valid;    // address cycle from the program counter
    logic        instr_last;  // this cycle ends an instruction
    logic [2:0]  reg_sel;     // register index
    logic        reg_wr;      // write strobe
    logic        reg_rd;      // read strobe
    logic [7:0]  reg_wdata;   // write data
    logic [7:0]  reg_rdata;   // read data, valid cycle after reg_rd
    logic        break_req;   // break request to processor
    logic        break_start; // processor begins the break sequence
    logic        rti_done;    // return from interrupt executed
    logic        in_wait;     // processor in wait mode
    logic        in_stop;     // processor in stop mode

    modport dev (input pc_addr, pc_valid, instr_last, reg_sel, reg_wr, reg_rd, reg_wdata,
                 break_start, rti_done, in_wait, in_stop,
                 output reg_rdata, break_req);
    modport cpu (output pc_addr, pc_valid, instr_last, reg_sel, reg_wr, reg_rd, reg_wdata,
                 break_start, rti_done, in_wait, in_stop,
                 input reg_rdata, break_req);
endinterface : brk_link_if
`default_nettype wire

/* verilog/brk_unit.sv */
// address breakpoint unit: control, address and standby-status registers
// assumes the processor end honours break_req and pulses break_start / rti_done
`timescale 1ns/1ps
`default_nettype none
module brk_unit
    import brk_pkg::*;
(
    input  wire logic   sys_clk,          // bus clock
    input  wire logic   rst,              // synchronous reset, high
    input  wire logic   ce,               // clock enable, freezes all state
    brk_link_if.dev     lnk,              // processor link
    input  wire logic   test_hv,          // test high voltage on reset pin
    output logic        timer_freeze,     // stop timer counters
    output logic        watchdog_disable, // hold watchdog off
    output logic        flag_clear_allow  // other status flags may be cleared
);
    logic        match_break_enable_ff;
    logic        break_active_ff;
    logic [7:0]  breakpoint_addr_high_ff;
    logic [7:0]  breakpoint_addr_low_ff;
    logic        wait_exit_flag_ff;
    logic        standby_exit_by_break_ff;
    logic        flag_clear_in_break_enable_ff;
    logic        in_break_ff;
    logic        break_req_ff;
    logic [7:0]  reg_rdata_ff;
    logic        timer_freeze_ff;
    logic        watchdog_disable_ff;
    logic        flag_clear_allow_ff;
    logic        addr_match;
    logic        force_break;
    logic        wr_ctrl;
    logic        wr_stby;
    logic        stby_clear_ok;

    // register write decode, used for several registers
    function automatic logic wr_hit(input logic [2:0] idx);
        wr_hit = lnk.reg_wr && (lnk.reg_sel == idx);
    endfunction : wr_hit

    // comparison runs on every address cycle, wait mode included
    assign addr_match  = match_break_enable_ff && lnk.pc_valid
                         && (lnk.pc_addr == {breakpoint_addr_high_ff, breakpoint_addr_low_ff});
    assign wr_ctrl     = wr_hit(IDX_CTRL_STATUS);
    assign force_break = wr_ctrl && lnk.reg_wdata[BIT_ACTIVE];
    assign wr_stby     = wr_hit(IDX_STANDBY);
    // inside break, standby flags are protected unless the clear enable is set
    assign stby_clear_ok = !in_break_ff || flag_clear_in_break_enable_ff;

    // match enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            match_break_enable_ff <= 1'b0;
        end else if (ce && wr_ctrl) begin
            match_break_enable_ff <= lnk.reg_wdata[BIT_MATCH_EN];
        end
    end

    // active bit: hardware set wins over a software write of zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            break_active_ff <= 1'b0;
        end else if (ce) begin
            if (addr_match || force_break) begin
                break_active_ff <= 1'b1;
            end else if (wr_ctrl) begin
                break_active_ff <= 1'b0;
            end
        end
    end

    // breakpoint address bytes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            breakpoint_addr_high_ff <= REG_RESET;
            breakpoint_addr_low_ff  <= REG_RESET;
        end else if (ce) begin
            if (wr_hit(IDX_ADDR_HIGH)) begin
                breakpoint_addr_high_ff <= lnk.reg_wdata;
            end
            if (wr_hit(IDX_ADDR_LOW)) begin
                breakpoint_addr_low_ff <= lnk.reg_wdata;
            end
        end
    end

    // flag clear enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_clear_in_break_enable_ff <= 1'b0;
        end else if (ce && wr_hit(IDX_FLAG_CLEAR)) begin
            flag_clear_in_break_enable_ff <= lnk.reg_wdata[BIT_CLR_EN];
        end
    end

    // standby exit flags: set at break start, the wait flag out of wait only, the standby flag out of wait or stop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_exit_flag_ff        <= 1'b0;
            standby_exit_by_break_ff <= 1'b0;
        end else if (ce) begin
            if (lnk.break_start && lnk.in_wait) begin
                wait_exit_flag_ff <= 1'b1;
            end else if (wr_stby && stby_clear_ok && !lnk.reg_wdata[BIT_WAIT_EXIT]) begin
                wait_exit_flag_ff <= 1'b0;
            end
            if (lnk.break_start && (lnk.in_wait || lnk.in_stop)) begin
                standby_exit_by_break_ff <= 1'b1;
            end else if (wr_stby && stby_clear_ok && !lnk.reg_wdata[BIT_STBY_EXIT]) begin
                standby_exit_by_break_ff <= 1'b0;
            end
        end
    end

    // request held from cause until the processor takes it; also wakes stop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            break_req_ff <= 1'b0;
        end else if (ce) begin
            if (lnk.break_start) begin
                break_req_ff <= 1'b0;
            end else if (addr_match || force_break) begin
                break_req_ff <= 1'b1;
            end
        end
    end

    // break state between sequence start and return from interrupt
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_break_ff <= 1'b0;
        end else if (ce) begin
            if (lnk.break_start) begin
                in_break_ff <= 1'b1;
            end else if (lnk.rti_done) begin
                in_break_ff <= 1'b0;
            end
        end
    end

    // side outputs registered; they lag the break state by one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_freeze_ff     <= 1'b0;
            watchdog_disable_ff <= 1'b0;
            flag_clear_allow_ff <= 1'b1;
        end else if (ce) begin
            timer_freeze_ff     <= in_break_ff;
            watchdog_disable_ff <= in_break_ff && test_hv;
            flag_clear_allow_ff <= stby_clear_ok;
        end
    end

    // read port never blocked by the break state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_ff <= REG_RESET;
        end else if (ce && lnk.reg_rd) begin
            unique case (lnk.reg_sel)
                IDX_CTRL_STATUS: reg_rdata_ff <= {match_break_enable_ff, break_active_ff, 6'h00};
                IDX_ADDR_HIGH:   reg_rdata_ff <= breakpoint_addr_high_ff;
                IDX_ADDR_LOW:    reg_rdata_ff <= breakpoint_addr_low_ff;
                IDX_STANDBY:     reg_rdata_ff <= {6'h00, wait_exit_flag_ff,
                                                  standby_exit_by_break_ff};
                IDX_FLAG_CLEAR:  reg_rdata_ff <= {flag_clear_in_break_enable_ff, 7'h00};
                default:         reg_rdata_ff <= REG_RESET; // unused indices read zero
            endcase
        end
    end

    assign lnk.break_req    = break_req_ff;
    assign lnk.reg_rdata    = reg_rdata_ff;
    assign timer_freeze     = timer_freeze_ff;
    assign watchdog_disable = watchdog_disable_ff;
    assign flag_clear_allow = flag_clear_allow_ff;
endmodule : brk_unit
`default_nettype wire

/* verif/brk_link_chk.sv */
// link checker: request raising, holding and register read-back
// assumes one sys_clk domain, ce held high, instantiated beside the link
`timescale 1ns/1ps
`default_nettype none
module brk_link_chk
    import brk_pkg::*;
(
    input wire logic        sys_clk,     // bus clock
    input wire logic        rst,         // sync reset
    input wire logic [15:0] pc_addr,     // program address
    input wire logic        pc_valid,    // address cycle
    input wire logic [2:0]  reg_sel,     // register index
    input wire logic        reg_wr,      // write strobe
    input wire logic        reg_rd,      // read strobe
    input wire logic [7:0]  reg_wdata,   // write data
    input wire logic [7:0]  reg_rdata,   // read data
    input wire logic        break_req,   // break request
    input wire logic        break_start, // break begins
    input wire logic        in_wait      // wait mode
);
    logic        en_ff; // shadow of the match enable
    logic [15:0] bp_ff; // shadow of the breakpoint
    // shadows follow link writes only, so a stuck device register shows up
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_ff <= 1'b0;
            bp_ff <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_sel)
                IDX_CTRL_STATUS: en_ff <= reg_wdata[BIT_MATCH_EN];
                IDX_ADDR_HIGH:   bp_ff[15:8] <= reg_wdata;
                IDX_ADDR_LOW:    bp_ff[7:0] <= reg_wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_match; pc_valid && en_ff && pc_addr == bp_ff; endsequence
    sequence s_force; reg_wr && reg_sel == IDX_CTRL_STATUS && reg_wdata[BIT_ACTIVE]; endsequence
    property p_match; s_match |=> break_req; endproperty
    property p_wait; in_wait ##0 s_match |=> break_req; endproperty
    property p_off; pc_valid && !en_ff && !break_req && !reg_wr |=> !break_req; endproperty
    property p_force; s_force |=> break_req; endproperty
    property p_hold; break_req && !break_start |=> break_req; endproperty
    property p_high; reg_rd && reg_sel == IDX_ADDR_HIGH |=> reg_rdata == bp_ff[15:8]; endproperty
    property p_en;
        reg_rd && reg_sel == IDX_CTRL_STATUS |=> reg_rdata[BIT_MATCH_EN] == en_ff;
    endproperty
    property p_act; reg_rd && reg_sel == IDX_CTRL_STATUS && break_req |=> reg_rdata[BIT_ACTIVE];
    endproperty
    a_match: assert property (p_match) else $error("match raised no request");
    a_wait: assert property (p_wait) else $error("match in wait raised no request");
    a_off: assert property (p_off) else $error("request while match disabled");
    a_force: assert property (p_force) else $error("forced break raised no request");
    a_hold: assert property (p_hold) else $error("request dropped before break start");
    a_high: assert property (p_high) else $error("high byte read back wrong");
    a_en: assert property (p_en) else $error("enable bit read back wrong");
    a_act: assert property (p_act) else $error("active bit clear during request");
endmodule : brk_link_chk
`default_nettype wire

/* verif/test_address_breakpoint_unit.sv */
// bench: unit and processor end joined by the link, software over wishbone
// assumes package constants and a 100 MHz sys_clk; reads carry notes to a monitor
`timescale 1ns/1ps
`default_nettype none
module test_address_breakpoint_unit;
    import brk_pkg::*;
    logic        sys_clk, rst, test_hv, wb_cyc, wb_stb, wb_we, wb_ack, irq;
    logic        timer_freeze, watchdog_disable, flag_clear_allow;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dat, wb_dat_o, rnd;
    logic [35:0] exp_q[$], msk_q[$], got;
    logic [15:0] bp;
    int          fails = 0, checks = 0, cyc_cnt = 0;
    brk_link_if lnk ();
    brk_unit u_brk_unit (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .lnk(lnk), .test_hv(test_hv),
        .timer_freeze(timer_freeze), .watchdog_disable(watchdog_disable),
        .flag_clear_allow(flag_clear_allow));
    brk_cpu_end u_brk_cpu_end (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .lnk(lnk),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .irq(irq));
    brk_link_chk u_brk_link_chk (.sys_clk(sys_clk), .rst(rst), .pc_addr(lnk.pc_addr),
        .pc_valid(lnk.pc_valid), .reg_sel(lnk.reg_sel), .reg_wr(lnk.reg_wr),
        .reg_rd(lnk.reg_rd), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
        .break_req(lnk.break_req), .break_start(lnk.break_start), .in_wait(lnk.in_wait));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    // one classic cycle: hold everything until ack is sampled, then a gap cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do @(posedge sys_clk); while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb
    task automatic rd(input logic [7:0] adr, input logic [35:0] e, input logic [35:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb(1'b0, adr, 32'h0000_0000);
    endtask : rd
    // p holds {irq, timer_freeze, watchdog_disable, flag_clear_allow}; b is {in break, request}
    task automatic st(input logic [3:0] p, input logic [3:0] pm, input logic [1:0] b);
        rd(WB_STATUS, {p, 22'h0, b, 8'h00}, {pm, 22'h0, 2'b11, 8'h00});
    endtask : st
    task automatic lwr(input logic [2:0] s, input logic [7:0] d);
        wb(1'b1, WB_CMD, {16'h0000, d, 5'h01, s});
    endtask : lwr
    // status holds the link answer only a few cycles after the command
    task automatic lrd(input logic [2:0] s, input logic [7:0] e);
        wb(1'b1, WB_CMD, {16'h0000, 8'h00, 5'h02, s});
        repeat (3) @(posedge sys_clk);
        rd(WB_STATUS, {28'h0000000, e}, 36'h0_0000_00FF);
    endtask : lrd
    task automatic pcw(input logic last, input logic [15:0] a);
        wb(1'b1, WB_ADDR, {15'h0000, last, a});
    endtask : pcw
    task automatic leave();
        lwr(IDX_CTRL_STATUS, 8'h80);
        wb(1'b1, WB_MODE, 32'h0000_0020);
    endtask : leave
    // monitor: each read answer is matched to the oldest note; also the hang limit
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt > 20000) begin
            fails++;
            final_report();
        end
        if (wb_ack && wb_cyc && !wb_we && exp_q.size() > 0) begin
            got = {irq, timer_freeze, watchdog_disable, flag_clear_allow, wb_dat_o} & msk_q[0];
            checks++;
            if (got !== (exp_q[0] & msk_q[0])) begin
                fails++;
                $display("[FAIL] %0t read %h got %h want %h", $time, wb_adr, got, exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    initial begin
        {rst, test_hv, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = {1'b1, 44'h0};
        rnd = 32'd68751;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        st(4'b0001, 4'hF, 2'b00);
        for (int i = 0; i < 8; i++) lrd(i[2:0], 8'h00);
        $display("test reset done");
        rnd = lfsr(lfsr(rnd));
        bp = rnd[15:0];
        lwr(IDX_ADDR_HIGH, bp[15:8]);
        lwr(IDX_ADDR_LOW, bp[7:0]);
        lrd(IDX_ADDR_LOW, bp[7:0]);
        pcw(1'b0, bp);
        st(4'b0001, 4'hF, 2'b00);
        lwr(IDX_CTRL_STATUS, 8'h80);
        pcw(1'b0, bp ^ 16'h8001);
        st(4'b0001, 4'hF, 2'b00);
        $display("test no match done");
        pcw(1'b0, bp);
        st(4'b0001, 4'hF, 2'b01);
        lrd(IDX_CTRL_STATUS, 8'hC0);
        wb(1'b1, WB_MODE, 32'h0000_0010);
        st(4'b0100, 4'hF, 2'b10);
        rd(WB_STATUS, {4'h0, VEC_NORMAL, 16'h0}, {4'h0, 16'hFFFF, 16'h0});
        rd(WB_MODE, {28'h0, SWI_OPCODE}, 36'h0_0000_00FF);
        lrd(IDX_ADDR_HIGH, bp[15:8]);
        test_hv <= 1'b1;
        st(4'b0010, 4'h2, 2'b10);
        wb(1'b1, WB_IRQ_MASK, 32'h0000_0001);
        st(4'b1000, 4'h8, 2'b10);
        wb(1'b1, WB_IRQ_STAT, 32'h0000_0001);
        st(4'b0000, 4'h8, 2'b10);
        wb(1'b1, WB_IRQ_MASK, 32'h0000_0000);
        lwr(IDX_CTRL_STATUS, 8'h80);
        lrd(IDX_CTRL_STATUS, 8'h80);
        wb(1'b1, WB_MODE, 32'h0000_0020);
        st(4'b0000, 4'h6, 2'b00);
        $display("test match break done");
        wb(1'b1, WB_MODE, 32'h0000_0001);
        pcw(1'b1, bp);
        repeat (2) @(posedge sys_clk); // request, then break start, follow the address cycle
        st(4'b0000, 4'h0, 2'b10);
        lrd(IDX_STANDBY, 8'h03);
        lwr(IDX_STANDBY, 8'h00);
        lrd(IDX_STANDBY, 8'h03);
        lwr(IDX_FLAG_CLEAR, 8'h80);
        st(4'b0001, 4'h1, 2'b10);
        lwr(IDX_STANDBY, 8'h00);
        lrd(IDX_STANDBY, 8'h00);
        leave();
        pcw(1'b0, bp - 16'h0001);
        st(4'b0000, 4'h0, 2'b00);
        $display("test wait done");
        wb(1'b1, WB_MODE, 32'h0000_0002);
        pcw(1'b1, bp);
        repeat (2) @(posedge sys_clk);
        st(4'b0000, 4'h0, 2'b10);
        rd(WB_STATUS, 36'h0, 36'h0_0000_0400);
        lrd(IDX_STANDBY, 8'h01);
        leave();
        $display("test stop done");
        lwr(IDX_CTRL_STATUS, 8'h40);
        st(4'b0000, 4'h0, 2'b01);
        wb(1'b1, WB_MODE, 32'h0000_0018);
        rd(WB_STATUS, {4'h0, VEC_MONITOR, 16'h0}, {4'h0, 16'hFFFF, 16'h0});
        leave();
        st(4'b0000, 4'h4, 2'b00);
        wb(1'b1, 8'h18, 32'hFFFF_FFFF);
        rd(8'h18, 36'h0, 36'h0_FFFF_FFFF);
        $display("test force and unmapped done");
        final_report();
    end
endmodule : test_address_breakpoint_unit
`default_nettype wire
